//--- dma_read_pkg.sv
// Constants, types and register map for the DMA read command unit.
// Assumes an APB master on the same clock as the media and DMA logic.
// Operation
// - Opcode 25h: extended DMA sector read
// - Fetch sectors from media, then deliver
// - Data leaves sixteen bits per transfer
// - Request line gates every data word
// - One interrupt per command, after transfer
// - Uncorrectable sector stops the read there
// - Extended count: current low, previous high
// - Zero count means 65,536 sectors
// - Report failing address, byte select picks half
// - Error bits placed at fixed positions
// - Track-zero and mark-missing always zero
// - Completion status: busy, fault, corrected zero
// - Opcode 60h: queued DMA sector read
// - Queued count taken from feature pair
// - Decode queued two-bit priority field
// - Forced media access bypasses cache
package dma_read_pkg;

    // Task-file slot indexes; byte address is index times four
    localparam logic [3:0] FEAT_CUR  = 4'h0;
    localparam logic [3:0] FEAT_PREV = 4'h1;
    localparam logic [3:0] CNT_CUR   = 4'h2;
    localparam logic [3:0] CNT_PREV  = 4'h3;
    localparam logic [3:0] SNUM_CUR  = 4'h4;
    localparam logic [3:0] SNUM_PREV = 4'h5;
    localparam logic [3:0] CLOW_CUR  = 4'h6;
    localparam logic [3:0] CLOW_PREV = 4'h7;
    localparam logic [3:0] CHIGH_CUR = 4'h8;
    localparam logic [3:0] CHIGH_PREV = 4'h9;
    localparam logic [3:0] DEV_HEAD  = 4'hA;
    localparam logic [3:0] CMD_SLOT  = 4'hB;
    localparam logic [3:0] ERR_SLOT  = 4'hC;
    localparam logic [3:0] STAT_SLOT = 4'hD;
    localparam logic [3:0] CTRL_SLOT = 4'hE;
    localparam int         TF_LAST   = 11;

    localparam logic [7:0] OP_READ_EXT    = 8'h25;
    localparam logic [7:0] OP_READ_QUEUED = 8'h60;

    localparam int ERR_CRC   = 7;
    localparam int ERR_UNC   = 6;
    localparam int ERR_IDNF  = 4;
    localparam int ERR_ABRT  = 2;
    localparam int CTRL_HOB  = 0;
    localparam int DH_FUA    = 7;
    localparam int TAG_HI    = 7;
    localparam int TAG_LO    = 3;
    localparam int QUEUED_PRIORITY_HI   = 7;
    localparam int QUEUED_PRIORITY_LO   = 6;

    localparam logic [1:0] QUEUED_PRIORITY_NORMAL = 2'h0;
    localparam logic [1:0] QUEUED_PRIORITY_ISOCH  = 2'h1;
    localparam logic [1:0] QUEUED_PRIORITY_HIGH   = 2'h2;

    localparam logic [16:0] MAX_SECTORS = 17'h10000;
    localparam int          SECTOR_WORDS = 256;
    localparam logic [7:0]  TF_RESET    = 8'h00;

    typedef enum logic [1:0] {
        st_idle,
        st_fetch,
        st_deliver
    } cmd_state_type;

    typedef struct packed {
        logic [47:0] lba;
        logic        forced_media_access;
        logic        high_queued_priority;
        logic [4:0]  tag;
    } media_req_type;

endpackage

//--- dma_read_cmd.sv
// Command unit for extended and queued DMA sector reads.
// Assumes media and DMA acknowledge logic share mclk_i with this block.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module dma_read_cmd (
    input  wire logic                       mclk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [7:0]                 paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    output dma_read_pkg::media_req_type     media_req_o,
    output logic                            media_rd_o,
    input  wire logic                       media_valid_i,
    input  wire logic [15:0]                media_data_i,
    input  wire logic                       media_done_i,
    input  wire logic                       media_unc_i,
    input  wire logic                       media_idnf_i,
    output logic                            dmarq_o,
    input  wire logic                       dmack_i,
    output logic      [15:0]                dma_data_o,
    input  wire logic                       crc_err_i,
    output logic                            intrq_o
);
    import dma_read_pkg::*;

    function automatic logic [15:0] pair16(input logic [7:0] hi,
                                           input logic [7:0] lo);
        pair16 = {hi, lo};
    endfunction

    // One opcode decode shared by start, abort and completion
    function automatic logic read_op(input logic [7:0] op);
        read_op = (op == OP_READ_EXT) || (op == OP_READ_QUEUED);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // APB decode

    logic [7:0]    tf [0:TF_LAST];
    logic [15:0]   sbuf [0:SECTOR_WORDS-1];
    cmd_state_type state;
    logic [47:0]   cur_lba;
    logic [47:0]   err_lba;
    logic [16:0]   remaining;
    logic [7:0]    fill_idx;
    logic [8:0]    rd_idx;
    logic          word_full;
    logic          high_order_byte_select;
    logic          f_crc;
    logic          f_unc;
    logic          f_idnf;
    logic          f_abrt;
    logic          busy;
    logic [3:0]    slot;
    logic          mapped;
    logic          wr_acc;
    logic          rd_acc;
    logic          start;
    logic          op_ok;
    logic          take;
    logic          sector_end;
    logic          complete;
    logic [16:0]   req_count;
    logic [7:0]    err_byte;
    logic [7:0]    stat_byte;
    logic [7:0]    rd_byte;

    assign slot     = paddr_i[5:2];
    assign mapped   = (paddr_i[7:6] == 2'h0) && (paddr_i[1:0] == 2'h0)
                    && (slot <= CTRL_SLOT);
    assign wr_acc   = psel_i && penable_i && pwrite_i && mapped;
    assign rd_acc   = psel_i && penable_i && !pwrite_i && mapped;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;

    // Task file is frozen while a command runs
    assign busy  = (state != st_idle);
    assign start = wr_acc && !busy && (slot == CMD_SLOT);
    assign op_ok = read_op(pwdata_i[7:0]);

    ////////////////////////////////////////////////////////////////////
    // Command decode

    always_comb begin
        req_count = 17'h0;
        if (pwdata_i[7:0] == OP_READ_QUEUED) begin
            // Queued read takes its count from the feature pair
            req_count = {1'b0, pair16(tf[FEAT_PREV],
                                      tf[FEAT_CUR])};
        end else begin
            req_count = {1'b0, pair16(tf[CNT_PREV],
                                      tf[CNT_CUR])};
        end
        if (req_count == 17'h0) begin
            req_count = MAX_SECTORS;
        end
    end

    // Read reports: error, status, and failing address by byte select
    always_comb begin
        // Spare bits, track-zero and mark-missing always read zero
        err_byte           = 8'h00;
        err_byte[ERR_CRC]  = f_crc;
        err_byte[ERR_UNC]  = f_unc;
        err_byte[ERR_IDNF] = f_idnf;
        err_byte[ERR_ABRT] = f_abrt;
    end
    assign stat_byte = {busy, !busy, 1'b0, !busy, 3'h0,
                        (f_crc | f_unc | f_idnf | f_abrt)};

    always_comb begin
        rd_byte = 8'h00;
        unique case (slot)
            SNUM_CUR:  rd_byte = high_order_byte_select ? err_lba[31:24]
                                     : err_lba[7:0];
            CLOW_CUR:  rd_byte = high_order_byte_select ? err_lba[39:32]
                                     : err_lba[15:8];
            CHIGH_CUR: rd_byte = high_order_byte_select ? err_lba[47:40]
                                     : err_lba[23:16];
            ERR_SLOT:  rd_byte = err_byte;
            STAT_SLOT: rd_byte = stat_byte;
            CTRL_SLOT: rd_byte = {7'h0, high_order_byte_select};
            default:   rd_byte = (slot <= CMD_SLOT) ? tf[slot] : 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= mapped ? {24'h0, rd_byte} : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Task file and control

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i <= TF_LAST; i++) begin
                tf[i] <= TF_RESET;
            end
        end else if (wr_acc && !busy && (slot <= CMD_SLOT)) begin
            // Address arrives as current/previous byte pairs
            tf[slot] <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            high_order_byte_select <= 1'b0;
        end else if (wr_acc && (slot == CTRL_SLOT)) begin
            high_order_byte_select <= pwdata_i[CTRL_HOB];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    assign take       = dmarq_o && dmack_i;
    assign sector_end = take && rd_idx[8];

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state     <= st_idle;
            remaining <= 17'h0;
            cur_lba   <= 48'h0;
        end else begin
            unique case (state)
                st_idle: begin
                    if (start && op_ok) begin
                        state     <= st_fetch;
                        remaining <= req_count;
                        cur_lba   <= {tf[CHIGH_PREV], tf[CLOW_PREV],
                                      tf[SNUM_PREV], tf[CHIGH_CUR],
                                      tf[CLOW_CUR], tf[SNUM_CUR]};
                    end
                end
                st_fetch: begin
                    if (media_done_i) begin
                        // Failing sector ends the read, nothing sent
                        state <= (media_unc_i || media_idnf_i) ?
                                 st_idle : st_deliver;
                    end
                end
                st_deliver: begin
                    if (sector_end) begin
                        remaining <= remaining - 17'h1;
                        cur_lba   <= cur_lba + 48'h1;
                        state <= (remaining == 17'h1) ?
                                 st_idle : st_fetch;
                    end
                end
            endcase
        end
    end

    assign complete = (state == st_fetch && media_done_i &&
                       (media_unc_i || media_idnf_i))
                    || (state == st_deliver && sector_end &&
                        remaining == 17'h1)
                    || (start && !op_ok);

    ////////////////////////////////////////////////////////////////////
    // Media side

    assign media_rd_o            = (state == st_fetch);
    assign media_req_o.lba       = cur_lba;
    assign media_req_o.forced_media_access       = tf[DEV_HEAD][DH_FUA];
    assign media_req_o.high_queued_priority = (tf[CNT_PREV][QUEUED_PRIORITY_HI:QUEUED_PRIORITY_LO]
                                    == QUEUED_PRIORITY_HIGH);
    assign media_req_o.tag       = tf[CNT_CUR][TAG_HI:TAG_LO];

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fill_idx <= 8'h0;
        end else if (state != st_fetch) begin
            fill_idx <= 8'h0;
        end else if (media_valid_i) begin
            fill_idx <= fill_idx + 8'h1;
        end
    end

    // Whole sector lands before any word is offered
    always_ff @(posedge mclk_i) begin
        if (state == st_fetch && media_valid_i) begin
            sbuf[fill_idx] <= media_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // DMA word path; one word every two cycles at best, kept simple

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_idx     <= 9'h0;
            word_full  <= 1'b0;
            dma_data_o <= 16'h0;
        end else if (state != st_deliver) begin
            rd_idx    <= 9'h0;
            word_full <= 1'b0;
        end else if (take) begin
            word_full <= 1'b0;
        end else if (!word_full && !rd_idx[8]) begin
            dma_data_o <= sbuf[rd_idx[7:0]];
            rd_idx     <= rd_idx + 9'h1;
            word_full  <= 1'b1;
        end
    end

    assign dmarq_o = (state == st_deliver) && word_full;

    ////////////////////////////////////////////////////////////////////
    // Error flags and completion interrupt

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            f_crc   <= 1'b0;
            f_unc   <= 1'b0;
            f_idnf  <= 1'b0;
            f_abrt  <= 1'b0;
            err_lba <= 48'h0;
        end else if (start) begin
            f_crc  <= 1'b0;
            f_unc  <= 1'b0;
            f_idnf <= 1'b0;
            f_abrt <= !op_ok;
        end else begin
            if (state == st_deliver && crc_err_i) begin
                f_crc <= 1'b1;
            end
            if (state == st_fetch && media_done_i) begin
                if (media_unc_i) begin
                    f_unc   <= 1'b1;
                    err_lba <= cur_lba;
                end
                if (media_idnf_i) begin
                    f_idnf  <= 1'b1;
                    err_lba <= cur_lba;
                end
            end
        end
    end

    // Set beats the status-read clear in the same cycle
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            intrq_o <= 1'b0;
        end else if (complete) begin
            intrq_o <= 1'b1;
        end else if (rd_acc && slot == STAT_SLOT) begin
            intrq_o <= 1'b0;
        end
    end

endmodule // dma_read_cmd

//--- dma_read_props.sv
// Port checker for the DMA read command unit.
// Assumes one clock domain; bound to dma_read_cmd by the bind below.
`timescale 1ns/1ps
module dma_read_props (
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        media_rd_o,
    input wire logic        media_done_i,
    input wire logic        media_unc_i,
    input wire logic        dmarq_o,
    input wire logic        dmack_i,
    input wire logic [15:0] dma_data_o,
    input wire logic        intrq_o
);
import dma_read_pkg::*;
logic busy;
wire  acc  = psel_i && penable_i;
wire  go   = acc && pwrite_i && paddr_i == 8'h2C && !busy;
wire  good = pwdata_i[7:0] == 8'h25 || pwdata_i[7:0] == 8'h60;
wire  stat_rd = acc && !pwrite_i && paddr_i == 8'h34;
////////////////////////////////////////////////////////////////
// Shadow of the busy state; commands written while busy are ignored
always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) busy <= 1'b0;
    else if (go && good) busy <= 1'b1;
    else if ($rose(intrq_o)) busy <= 1'b0;
end
////////////////////////////////////////////////////////////////
default clocking cb @(posedge mclk_i); endclocking
default disable iff (sys_rst_i);
sequence take_s; dmarq_o && dmack_i; endsequence
sequence stat_rd_s; acc && !pwrite_i && paddr_i == 8'h34; endsequence
sequence unc_s; media_done_i && media_unc_i && media_rd_o; endsequence
ready_high_a: assert property (acc |-> pready_o)
    else $error("pready low in access");
map_error_a: assert property (acc && (paddr_i > 8'h38 ||
    paddr_i[1:0] != 2'b00) |-> pslverr_o) else $error("no slverr");
cmd_fetch_a: assert property (go && good |-> ##[1:2] media_rd_o)
    else $error("command did not start fetch");
bad_abort_a: assert property (go && !good |-> ##[1:2] intrq_o)
    else $error("bad opcode not ended");
fetch_first_a: assert property (media_rd_o |-> !dmarq_o)
    else $error("data offered during fetch");
word_hold_a: assert property (dmarq_o && !dmack_i |=>
    dmarq_o && $stable(dma_data_o)) else $error("word not held");
take_drop_a: assert property (take_s |=> !dmarq_o)
    else $error("request kept after take");
unc_stop_a: assert property (unc_s |=> !dmarq_o [*4])
    else $error("data after bad sector");
irq_stand_a: assert property (intrq_o && !stat_rd |=> intrq_o)
    else $error("interrupt dropped early");
irq_clear_a: assert property (stat_rd_s ##0 !busy |=> !intrq_o)
    else $error("interrupt kept after status read");
endmodule // dma_read_props
bind dma_read_cmd dma_read_props i_props (.mclk_i, .sys_rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o,
    .media_rd_o, .media_done_i, .media_unc_i, .dmarq_o, .dmack_i,
    .dma_data_o, .intrq_o);

//--- dma_host.sv
// Host slave DMA channel model that takes words from the unit.
// Assumes the stall input is driven by the bench each cycle.
`timescale 1ns/1ps
module dma_host (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        stall_i,
    input  wire logic        dmarq_i,
    input  wire logic [15:0] data_i,
    output logic             dmack_o,
    output logic             got_o,
    output logic      [15:0] word_o
);
// Channel armed from reset, so before any command
always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        dmack_o <= 1'b0;
        got_o <= 1'b0;
        word_o <= 16'h0000;
    end else begin
        got_o <= dmarq_i && dmack_o;
        if (dmarq_i && dmack_o) begin
            word_o <= data_i;
            dmack_o <= 1'b0;
        end else if (dmarq_i && !stall_i) dmack_o <= 1'b1;
    end
end
endmodule // dma_host

//--- extended_dma_read_command_unit_bench.sv
// Self-checking bench for the DMA read command unit.
// Assumes the channel model and checker are compiled first.
`timescale 1ns/1ps
module extended_dma_read_command_unit_bench;
import dma_read_pkg::*;
logic          mclk_i, sys_rst_i, psel_i, penable_i, pwrite_i, err;
logic          pready_o, pslverr_o, media_rd_o, media_valid_i, stall;
logic          media_done_i, media_unc_i, media_idnf_i, dmarq_o, got;
logic          dmack_i, crc_err_i, intrq_o, irq_q;
logic [7:0]    paddr_i;
logic [31:0]   pwdata_i, prdata_o, rd;
logic [15:0]   media_data_i, dma_data_o, word;
logic [47:0]   lba;
logic [4:0]    tag;
logic [7:0]    bad[3] = '{8'h3C, 8'h40, 8'h31};
logic [15:0]   exp_q[$];
media_req_type media_req_o;
int            failures, num_checks, cyc, ncmd, nirq;
dma_read_cmd i_dut (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .media_req_o,
    .media_rd_o, .media_valid_i, .media_data_i, .media_done_i,
    .media_unc_i, .media_idnf_i, .dmarq_o, .dmack_i, .dma_data_o,
    .crc_err_i, .intrq_o);
dma_host i_host (.mclk_i, .sys_rst_i, .stall_i(stall), .dmarq_i(dmarq_o),
    .data_i(dma_data_o), .dmack_o(dmack_i), .got_o(got), .word_o(word));
initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
end
////////////////////////////////////////////////////////////////
task automatic chk(input string n, input logic [47:0] e, g);
    num_checks++;
    if (e !== g) begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
endtask
task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
// Idle cycle first, so back-to-back calls never drive psel twice at once
task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
endtask
task automatic rdc(input logic [7:0] a, e, input string n);
    apb(1'b0, a, 8'h00);
    chk(n, 48'(e), 48'(rd[7:0]));
endtask
task automatic load(input logic [47:0] a, input logic [15:0] c, f,
                    input logic [7:0] dh);
    logic [7:0] b[11];
    b = '{f[7:0], f[15:8], c[7:0], c[15:8], a[7:0], a[31:24], a[15:8],
          a[39:32], a[23:16], a[47:40], dh};
    for (int i = 0; i < 11; i++) apb(1'b1, 8'(4 * i), b[i]);
endtask
// Fault code: bit 0 uncorrectable, bit 1 address not found
task automatic sector(input logic [47:0] a, input logic [1:0] flt,
                      input logic [6:0] at, msk);
    logic [15:0] w;
    while (media_rd_o !== 1'b1) @(posedge mclk_i);
    chk("media lba", a, media_req_o.lba);
    chk("media attr", 48'(at), 48'(media_req_o[6:0] & msk));
    for (int i = 0; i < SECTOR_WORDS; i++) begin
        w = 16'($urandom);
        @(posedge mclk_i);
        media_valid_i <= 1'b1;
        media_data_i <= w;
        if (flt == 2'h0) exp_q.push_back(w);
    end
    @(posedge mclk_i);
    media_valid_i <= 1'b0;
    media_done_i <= 1'b1;
    media_unc_i <= flt[0];
    media_idnf_i <= flt[1];
    @(posedge mclk_i);
    media_done_i <= 1'b0;
    media_unc_i <= 1'b0;
    media_idnf_i <= 1'b0;
    @(posedge mclk_i);
endtask
task automatic finish_cmd(input logic [7:0] st, er);
    while (intrq_o !== 1'b1) @(posedge mclk_i);
    @(posedge mclk_i);
    chk("words left", 48'h0, 48'(exp_q.size()));
    chk("irq count", 48'(ncmd), 48'(nirq));
    rdc(8'h34, st, "status");
    rdc(8'h30, er, "error");
    @(posedge mclk_i);
    chk("irq cleared", 48'h0, 48'(intrq_o));
    $display("test command done");
endtask
task automatic fail_at(input logic [47:0] a);
    for (int h = 0; h < 2; h++) begin
        apb(1'b1, 8'h38, 8'(h));
        for (int k = 0; k < 3; k++)
            rdc(8'(16 + 8 * k), a[24 * h + 8 * k +: 8], "fail lba");
    end
    apb(1'b1, 8'h38, 8'h00);
endtask
////////////////////////////////////////////////////////////////
always @(posedge mclk_i) begin
    stall <= ($urandom % 3) == 0;
    cyc++;
    if (intrq_o === 1'b1 && irq_q !== 1'b1) nirq++;
    irq_q <= intrq_o;
    if (got === 1'b1) begin
        if (exp_q.size() == 0) chk("extra word", 48'h0, 48'h1);
        else chk("dma word", 48'(exp_q.pop_front()), 48'(word));
    end
    if (cyc == 20000) begin
        failures++;
        results();
    end
end
initial begin
    void'($urandom(32'h2514));
    {psel_i, penable_i, pwrite_i, media_valid_i, media_done_i} = '0;
    {media_unc_i, media_idnf_i, crc_err_i} = '0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    media_data_i = 16'h0;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rdc(8'h34, 8'h50, "idle status");
    rdc(8'h30, 8'h00, "idle error");
    foreach (bad[i]) begin
        apb(1'b0, bad[i], 8'h00);
        chk("slverr", 48'h1, 48'(err));
    end
    $display("test map done");
    lba = {16'($urandom), $urandom};
    load(lba, 16'h0002, 16'h0000, 8'h80);
    apb(1'b1, 8'h2C, OP_READ_EXT);
    ncmd++;
    sector(lba, 2'h0, 7'h40, 7'h40);
    sector(lba + 48'h1, 2'h0, 7'h40, 7'h40);
    crc_err_i <= 1'b1;
    @(posedge mclk_i);
    crc_err_i <= 1'b0;
    finish_cmd(8'h51, 8'h80);
    for (int p = 0; p < 3; p++) begin
        tag = 5'($urandom);
        lba = {16'($urandom), $urandom};
        load(lba, {2'(p), 6'h00, tag, 3'h0}, 16'h0001, 8'h00);
        apb(1'b1, 8'h2C, OP_READ_QUEUED);
        ncmd++;
        sector(lba, {1'b0, p == 2}, {1'b0, p == 2, tag}, 7'h7F);
        finish_cmd(p == 2 ? 8'h51 : 8'h50, p == 2 ? 8'h40 : 8'h00);
    end
    rdc(8'h28, 8'h00, "dev head");
    fail_at(lba);
    lba = {16'($urandom), $urandom};
    load(lba, 16'h0000, 16'h0001, 8'h00);
    apb(1'b1, 8'h2C, OP_READ_EXT);
    ncmd++;
    sector(lba, 2'h0, 7'h00, 7'h40);
    sector(lba + 48'h1, 2'h2, 7'h00, 7'h40);
    finish_cmd(8'h51, 8'h10);
    fail_at(lba + 48'h1);
    apb(1'b1, 8'h2C, 8'hE9);
    ncmd++;
    finish_cmd(8'h51, 8'h04);
    results();
end
endmodule // extended_dma_read_command_unit_bench
